// ===== verilog/typec_cc_pkg.sv
package typec_cc_pkg;
   // Register byte addresses (printed offsets are not all multiples of four: index * 4)
   localparam logic [7:0] ACTION_CONTROL_IDX = 8'h28;
   localparam logic [7:0] ROLE_PREFERENCE_IDX = 8'h29;
   localparam logic [7:0] CC_STATUS_IDX = 8'h2a;
   localparam logic [9:0] ACTION_CONTROL_ADDR = 10'h0a0;
   localparam logic [9:0] ROLE_PREFERENCE_ADDR = 10'h0a4;
   localparam logic [9:0] CC_STATUS_ADDR = 10'h0a8;
   // Field positions of cc_action_control
   localparam int FORCE_ERROR_BIT = 7;
   localparam int SINK_HOLD_BIT = 6;
   localparam int SNK_SRC_SWAP_BIT = 5;
   localparam int SRC_SNK_SWAP_BIT = 4;
   localparam int VCONN_SWAP_BIT = 3;
   localparam int VCONN_CTL_BIT = 2;
   localparam int SRC_RESET_BIT = 1;
   localparam int SNK_RESET_BIT = 0;
   // Field positions of cc_role_preference
   localparam int TRY_SINK_BIT = 3;
   localparam int PREFER_SINK_BIT = 2;
   localparam int DUTY_LSB = 0;
   localparam logic [7:0] ACTION_CONTROL_RESET = 8'h00;
   localparam logic [7:0] ROLE_PREFERENCE_RESET = 8'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int HOLD_TIME_MS = 1100;
   localparam int HOLD_CYCLES = (HOLD_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEBOUNCE_TIME_US = 10;
   localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TOGGLE_PERIOD_US = 75;
   localparam int TOGGLE_CYCLES = (TOGGLE_PERIOD_US * 1000) / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_DISABLED = 4'h0,
      ST_UNATT_SNK = 4'h1,
      ST_UNATT_SRC = 4'h2,
      ST_ATTWAIT_SRC = 4'h3,
      ST_TRY_SNK = 4'h4,
      ST_TRYWAIT_SRC = 4'h5,
      ST_ATT_SNK = 4'h6,
      ST_ATT_SRC = 4'h7,
      ST_ERROR_RECOVERY = 4'h8
   } cc_state_t;

   typedef struct packed {
      logic ccDetect;
      logic sinkDetect;
      logic sourceDetect;
      logic dualRole;
      logic sinkSourceToggle;
      logic inputSupplyValid;
   } cc_sense_t;

   typedef struct packed {
      logic powerRoleSource;
      logic vconnSource;
      logic vconnExtOn;
      logic vconnIntOn;
   } cc_drive_t;
endpackage

// ===== verilog/typec_cc_state_control.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Operation
// R1 - Writing force-error sends the machine to ErrorRecovery; bit self-clears after.
// R2 - Hold bit set keeps Attached.SNK for at least 1.1s without VBUS.
// R3 - Hold clear: leave Attached.SNK after supply low longer than debounce.
// R4 - Hold bit clears itself, no earlier than 1.1s after being set.
// R5 - Sink-to-source swap request makes the machine become source.
// R6 - Software writes the swap request back to zero after swap.
// R7 - VCONN swap write toggles VCONN role; zero does nothing; self-clears.
// R8 - Source reset write goes straight to Unattached.SRC; reads as zero.
// R9 - Sink reset write goes straight to Unattached.SNK; reads as zero.
// R10 - Try-sink: AttachWait.SRC goes Try.SNK then Attached.SNK or TryWait.SRC.
// R11 - Try-sink outranks prefer-sink when both are set.
// R12 - Duty field sets source share of toggle period: 35/40/45/50 percent.
// R13 - Source-to-sink swap request makes the machine become sink.
// R14 - Prefer-sink: Unattached.SRC passes Try.SNK to Unattached.SNK.
// R15 - VCONN control clear forces both VCONN switches off.
module typec_cc_state_control #(
   parameter int HOLD_COUNT = typec_cc_pkg::HOLD_CYCLES,
   parameter int DEBOUNCE_COUNT = typec_cc_pkg::DEBOUNCE_CYCLES,
   parameter int TOGGLE_COUNT = typec_cc_pkg::TOGGLE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire typec_cc_pkg::cc_sense_t sensePins,
   output typec_cc_pkg::cc_drive_t drive,
   output typec_cc_pkg::cc_state_t ccState
);
   import typec_cc_pkg::*;

   cc_sense_t senseMeta;
   cc_sense_t sense;
   logic [7:0] actionCtl;
   logic [7:0] rolePref;
   logic [31:0] holdCnt;
   logic [31:0] debounceCnt;
   logic [31:0] toggleCnt;
   logic vconnRole;
   logic powerSource;
   logic supplyLost;
   logic toggleSrcPhase;
   logic [31:0] srcShare;
   logic wrAccess;
   logic mapped;

   function automatic logic isMapped(input logic [31:0] addr);
      isMapped = addr[31:10] == 22'h0 &&
         (addr[9:0] == ACTION_CONTROL_ADDR || addr[9:0] == ROLE_PREFERENCE_ADDR || addr[9:0] == CC_STATUS_ADDR);
   endfunction

   assign pready = 1'b1;
   assign mapped = isMapped(paddr);
   assign pslverr = psel & penable & ~mapped;
   assign wrAccess = clkEn & psel & penable & pwrite & mapped;

   // Two-stage sync of cable-side sensing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         senseMeta <= '0;
         sense <= '0;
      end else if (clkEn) begin
         senseMeta <= sensePins;
         sense <= senseMeta;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (clkEn && psel && !penable && !pwrite) begin
         if (paddr[9:0] == ACTION_CONTROL_ADDR && mapped) begin
            prdata <= {24'h0, actionCtl};
         end else if (paddr[9:0] == ROLE_PREFERENCE_ADDR && mapped) begin
            prdata <= {24'h0, rolePref};
         end else if (paddr[9:0] == CC_STATUS_ADDR && mapped) begin
            prdata <= {24'h0, vconnRole, powerSource, toggleSrcPhase, 1'b0, ccState};
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rolePref <= ROLE_PREFERENCE_RESET;
      end else if (wrAccess && paddr[9:0] == ROLE_PREFERENCE_ADDR) begin
         rolePref <= {4'h0, pwdata[3:0]};
      end
   end

   // Action bits: one-shot bits clear on the first enabled cycle without a write, acted on or not
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         actionCtl <= ACTION_CONTROL_RESET;
      end else if (clkEn) begin
         if (wrAccess && paddr[9:0] == ACTION_CONTROL_ADDR) begin
            actionCtl <= pwdata[7:0];
         end else begin
            // R1 force-error self clear
            actionCtl[FORCE_ERROR_BIT] <= 1'b0;
            // R7 vconn swap self clear
            actionCtl[VCONN_SWAP_BIT] <= 1'b0;
            // R8 source reset clears
            actionCtl[SRC_RESET_BIT] <= 1'b0;
            // R9 sink reset clears
            actionCtl[SNK_RESET_BIT] <= 1'b0;
            // R4 hold expires after count
            if (actionCtl[SINK_HOLD_BIT] && holdCnt >= HOLD_COUNT - 1) begin
               actionCtl[SINK_HOLD_BIT] <= 1'b0;
            end
         end
      end
   end

   // R4 hold timer, restarted by any write to the action control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         holdCnt <= 32'h0;
      end else if (clkEn) begin
         if (wrAccess && paddr[9:0] == ACTION_CONTROL_ADDR) begin
            holdCnt <= 32'h0;
         end else if (actionCtl[SINK_HOLD_BIT]) begin
            holdCnt <= holdCnt + 32'h1;
         end
      end
   end

   // R3 supply-loss debounce
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         debounceCnt <= 32'h0;
      end else if (clkEn) begin
         if (sense.inputSupplyValid) begin
            debounceCnt <= 32'h0;
         end else if (debounceCnt <= DEBOUNCE_COUNT) begin
            debounceCnt <= debounceCnt + 32'h1;
         end
      end
   end
   assign supplyLost = debounceCnt > DEBOUNCE_COUNT;

   // R12 source share of toggle period in percent
   always_comb begin
      case (rolePref[DUTY_LSB +: 2])
         2'b00: srcShare = 32'd35;
         2'b01: srcShare = 32'd40;
         2'b10: srcShare = 32'd45;
         default: srcShare = 32'd50;
      endcase
   end

   // R12 toggle period counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         toggleCnt <= 32'h0;
      end else if (clkEn) begin
         if (toggleCnt >= TOGGLE_COUNT - 1) begin
            toggleCnt <= 32'h0;
         end else begin
            toggleCnt <= toggleCnt + 32'h1;
         end
      end
   end
   assign toggleSrcPhase = (toggleCnt * 100) < (srcShare * TOGGLE_COUNT);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ccState <= ST_DISABLED;
      end else if (clkEn) begin
         if (actionCtl[FORCE_ERROR_BIT]) begin
            // R1 forced error recovery
            ccState <= ST_ERROR_RECOVERY;
         end else if (actionCtl[SRC_RESET_BIT]) begin
            // R8 reset to source
            ccState <= ST_UNATT_SRC;
         end else if (actionCtl[SNK_RESET_BIT]) begin
            // R9 reset to sink
            ccState <= ST_UNATT_SNK;
         end else if (!sense.ccDetect) begin
            ccState <= ST_DISABLED;
         end else begin
            case (ccState)
               ST_DISABLED: ccState <= ST_UNATT_SNK;
               ST_ERROR_RECOVERY: ccState <= ST_UNATT_SNK;
               ST_UNATT_SNK: begin
                  if (sense.sourceDetect) begin
                     ccState <= ST_ATT_SNK;
                  // R12 toggle into source phase
                  end else if (sense.dualRole && sense.sinkSourceToggle && toggleSrcPhase) begin
                     ccState <= ST_UNATT_SRC;
                  end
               end
               ST_UNATT_SRC: begin
                  if (sense.sinkDetect && sense.dualRole && !rolePref[TRY_SINK_BIT] && rolePref[PREFER_SINK_BIT]) begin
                     // R14 prefer-sink detour
                     ccState <= ST_TRY_SNK;
                  end else if (sense.sinkDetect) begin
                     ccState <= ST_ATTWAIT_SRC;
                  end else if (sense.dualRole && sense.sinkSourceToggle && !toggleSrcPhase) begin
                     ccState <= ST_UNATT_SNK;
                  end
               end
               ST_ATTWAIT_SRC: begin
                  if (!sense.sinkDetect) begin
                     ccState <= ST_UNATT_SNK;
                  // R10 R11 try-sink has priority
                  end else if (sense.dualRole && rolePref[TRY_SINK_BIT]) begin
                     ccState <= ST_TRY_SNK;
                  end else begin
                     ccState <= ST_ATT_SRC;
                  end
               end
               ST_TRY_SNK: begin
                  // R10 resolve try-sink
                  if (sense.sourceDetect) begin
                     ccState <= ST_ATT_SNK;
                  end else if (rolePref[TRY_SINK_BIT]) begin
                     ccState <= ST_TRYWAIT_SRC;
                  end else begin
                     // R14 back to unattached sink
                     ccState <= ST_UNATT_SNK;
                  end
               end
               ST_TRYWAIT_SRC: ccState <= sense.sinkDetect ? ST_ATT_SRC : ST_UNATT_SNK;
               ST_ATT_SNK: begin
                  // R5 swap to source
                  if (actionCtl[SNK_SRC_SWAP_BIT]) begin
                     ccState <= ST_ATT_SRC;
                  // R2 R3 hold versus debounced supply loss
                  end else if (!actionCtl[SINK_HOLD_BIT] && supplyLost) begin
                     ccState <= ST_UNATT_SNK;
                  end
               end
               ST_ATT_SRC: begin
                  // R13 swap to sink
                  if (actionCtl[SRC_SNK_SWAP_BIT]) begin
                     ccState <= ST_ATT_SNK;
                  end else if (!sense.sinkDetect) begin
                     ccState <= ST_UNATT_SNK;
                  end
               end
               default: ccState <= ST_ERROR_RECOVERY;
            endcase
         end
      end
   end

   // Power and VCONN roles follow state; swap request flips VCONN role
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vconnRole <= 1'b0;
         powerSource <= 1'b0;
      end else if (clkEn) begin
         powerSource <= ccState == ST_ATT_SRC || ccState == ST_UNATT_SRC || ccState == ST_ATTWAIT_SRC ||
            ccState == ST_TRYWAIT_SRC;
         if (ccState != ST_ATT_SRC && ccState != ST_ATT_SNK) begin
            vconnRole <= 1'b0;
         // R7 vconn role swap
         end else if (actionCtl[VCONN_SWAP_BIT]) begin
            vconnRole <= ~vconnRole;
         end else if (ccState == ST_ATT_SRC && $past(ccState) != ST_ATT_SRC && $past(ccState) != ST_ATT_SNK) begin
            vconnRole <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drive <= '0;
      end else if (clkEn) begin
         drive.powerRoleSource <= powerSource;
         drive.vconnSource <= vconnRole;
         // R15 vconn switches gated by control
         drive.vconnExtOn <= actionCtl[VCONN_CTL_BIT] & vconnRole;
         drive.vconnIntOn <= actionCtl[VCONN_CTL_BIT] & vconnRole;
      end
   end

endmodule // typec_cc_state_control

// ===== test/typec_cc_state_control_checker.sv
`timescale 1ns/1ps
module typec_cc_state_control_checker #(
   parameter int HOLD_COUNT = 100,
   parameter int DEBOUNCE_COUNT = 5,
   parameter int TOGGLE_COUNT = 100
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire typec_cc_pkg::cc_sense_t sensePins,
   input wire typec_cc_pkg::cc_drive_t drive,
   input wire typec_cc_pkg::cc_state_t ccState
);
   import typec_cc_pkg::*;
   logic acc;
   logic mapped;
   logic vconnCtl;
   assign acc = psel && penable && clkEn;
   assign mapped = paddr == {22'h0, ACTION_CONTROL_ADDR} || paddr == {22'h0, ROLE_PREFERENCE_ADDR}
      || paddr == {22'h0, CC_STATUS_ADDR};
   // Shadow of the enable, since the register itself is not visible here
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vconnCtl <= 1'b0;
      end else if (acc && pwrite && paddr == {22'h0, ACTION_CONTROL_ADDR}) begin
         vconnCtl <= pwdata[VCONN_CTL_BIT];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_act(logic [7:0] v);
      acc && pwrite && paddr == {22'h0, ACTION_CONTROL_ADDR} && pwdata[7:0] == v && sensePins.ccDetect;
   endsequence
   chk_src_reset: assert property (s_act(8'h02) |-> ##[1:3] ccState == ST_UNATT_SRC)
      else $error("source reset missed");
   chk_snk_reset: assert property (s_act(8'h01) |-> ##[1:3] ccState == ST_UNATT_SNK)
      else $error("sink reset missed");
   chk_force_error: assert property (s_act(8'h80) |-> ##[1:3] ccState == ST_ERROR_RECOVERY)
      else $error("error recovery missed");
   chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped access");
   chk_vconn_off: assert property (!vconnCtl [*4] |-> !drive.vconnExtOn && !drive.vconnIntOn)
      else $error("vconn switch on while disabled");
   chk_detect_off: assert property (!sensePins.ccDetect [*4] |-> ccState == ST_DISABLED)
      else $error("not disabled without detect");
   chk_read_upper: assert property (acc && !pwrite && mapped |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule // typec_cc_state_control_checker
bind typec_cc_state_control typec_cc_state_control_checker #(.HOLD_COUNT(HOLD_COUNT),
   .DEBOUNCE_COUNT(DEBOUNCE_COUNT), .TOGGLE_COUNT(TOGGLE_COUNT)) i_chk (.clk(clk), .sys_rst(sys_rst),
   .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sensePins(sensePins), .drive(drive),
   .ccState(ccState));

// ===== test/typec_port_partner.sv
`timescale 1ns/1ps
module typec_port_partner (
   input wire logic present,
   input wire logic toggleEn,
   input wire logic [1:0] partnerRole,
   input wire logic supplyOk,
   input wire typec_cc_pkg::cc_drive_t drive,
   output typec_cc_pkg::cc_sense_t sense
);
   import typec_cc_pkg::*;
   // Role 1 terminates as a sink, role 2 as a source, VBUS valid follows supplyOk; a sourcing partner backs off while this port sources
   assign sense = {present, present && partnerRole == 2'd1,
      present && partnerRole == 2'd2 && drive.powerRoleSource !== 1'b1, present, toggleEn, present && supplyOk};
endmodule // typec_port_partner

// ===== test/typec_cc_state_control_tb.sv
`timescale 1ns/1ps
module typec_cc_state_control_tb;
   import typec_cc_pkg::*;
   localparam int HOLD = 100;
   localparam int TOG = 100;
   localparam logic [31:0] A_ACT = {22'h0, ACTION_CONTROL_ADDR};
   localparam logic [31:0] A_PREF = {22'h0, ROLE_PREFERENCE_ADDR};
   localparam logic [31:0] A_STAT = {22'h0, CC_STATUS_ADDR};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic present = 1'b0;
   logic toggleEn = 1'b0;
   logic clkEn = 1'b1;
   logic [1:0] partnerRole = 2'h0;
   logic supplyOk = 1'b0;
   logic [15:0] seen;
   cc_state_t frozen;
   int prefList[$] = '{0, 8, 12, 4};
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cc_sense_t sensePins;
   cc_drive_t drive;
   cc_state_t ccState;
   logic [31:0] rd;
   logic err;
   logic v;
   int miscompares = 0;
   int cmp_count = 0;
   int actModel = int'(ACTION_CONTROL_RESET);
   int prefModel = int'(ROLE_PREFERENCE_RESET);
   int dutyPct[$] = '{35, 40, 45, 50};
   int cnt;
   always #5 clk = ~clk;
   typec_cc_state_control #(.HOLD_COUNT(HOLD), .DEBOUNCE_COUNT(5), .TOGGLE_COUNT(TOG)) i_typec_cc_state_control (
      .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sensePins(sensePins), .drive(drive), .ccState(ccState));
   typec_port_partner i_typec_port_partner (.present(present), .toggleEn(toggleEn), .partnerRole(partnerRole),
      .supplyOk(supplyOk), .drive(drive), .sense(sensePins));
   task automatic setPartner(input logic [1:0] r, input logic s);
      @(posedge clk);
      partnerRole <= r;
      supplyOk <= s;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [31:0] a, input int e);
      apb(1'b0, a, 32'h0);
      check(rd, 32'(e));
      check({31'h0, err}, 32'h0);
   endtask
   task automatic waits(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic endTest(input string name);
      $display("%s finished: %0d compares, %0d mismatches", name, cmp_count, miscompares);
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
   initial begin
      cnt = $urandom(32'h20bd);
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      present <= 1'b1;
      waits(4);
      rdchk(A_ACT, actModel);
      rdchk(A_PREF, prefModel);
      endTest("reset values");
      for (int i = 0; i < 6; i++) begin
         prefModel = $urandom & 32'h0f;
         apb(1'b1, A_PREF, prefModel);
         rdchk(A_PREF, prefModel);
      end
      prefModel = 0;
      apb(1'b1, A_PREF, prefModel);
      endTest("preference");
      foreach (dutyPct[i]) begin
         apb(1'b1, A_ACT, i == 0 ? 32'h80 : i == 1 ? 32'h02 : 32'h01);
         waits(2);
         check(ccState, i == 0 ? ST_ERROR_RECOVERY : i == 1 ? ST_UNATT_SRC : ST_UNATT_SNK);
         rdchk(A_ACT, actModel);
      end
      waits(5);
      check(ccState, ST_UNATT_SNK);
      endTest("one-shot resets");
      setPartner(2'd2, 1'b1);
      waits(6);
      check(ccState, ST_ATT_SNK);
      setPartner(2'd0, 1'b0);
      waits(4);
      check(ccState, ST_ATT_SNK);
      waits(8);
      check(ccState, ST_UNATT_SNK);
      endTest("supply loss");
      setPartner(2'd2, 1'b1);
      waits(6);
      apb(1'b1, A_ACT, 32'h40);
      setPartner(2'd0, 1'b0);
      rdchk(A_ACT, 32'h40);
      waits(HOLD - 30);
      check(ccState, ST_ATT_SNK);
      rdchk(A_ACT, 32'h40);
      waits(30);
      check(ccState, ST_UNATT_SNK);
      rdchk(A_ACT, 0);
      endTest("sink hold");
      setPartner(2'd2, 1'b1);
      waits(6);
      check(ccState, ST_ATT_SNK);
      setPartner(2'd1, 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      v = rd[7];
      actModel = 32'h24;
      apb(1'b1, A_ACT, actModel);
      waits(3);
      check(ccState, ST_ATT_SRC);
      rdchk(A_ACT, actModel);
      // Software clears the swap request once the swap is done
      apb(1'b1, A_ACT, 32'h0c);
      actModel = 32'h04;
      waits(4);
      rdchk(A_ACT, actModel);
      apb(1'b0, A_STAT, 32'h0);
      check({31'h0, rd[7]}, {31'h0, ~v});
      check({30'h0, drive.vconnExtOn, drive.vconnIntOn}, 32'h3);
      apb(1'b1, A_ACT, 32'h04);
      waits(4);
      apb(1'b0, A_STAT, 32'h0);
      check({31'h0, rd[7]}, {31'h0, ~v});
      actModel = 32'h14;
      apb(1'b1, A_ACT, actModel);
      waits(3);
      check(ccState, ST_ATT_SNK);
      rdchk(A_ACT, actModel);
      actModel = 0;
      apb(1'b1, A_ACT, actModel);
      waits(4);
      check({30'h0, drive.vconnExtOn, drive.vconnIntOn}, 32'h0);
      endTest("swap and vconn");
      foreach (prefList[k]) begin
         prefModel = prefList[k];
         apb(1'b1, A_PREF, prefModel);
         apb(1'b1, A_ACT, 32'h02);
         seen = 16'h0;
         repeat (8) begin
            @(negedge clk);
            seen |= 16'h1 << ccState;
         end
         check(ccState, prefModel == 4 ? ST_UNATT_SNK : ST_ATT_SRC);
         check({31'h0, seen[ST_TRY_SNK]}, {31'h0, prefModel != 0});
         check({31'h0, seen[ST_TRYWAIT_SRC]}, {31'h0, (prefModel & 8) != 0});
         check({31'h0, seen[ST_ATTWAIT_SRC]}, {31'h0, prefModel != 4});
      end
      endTest("try and prefer sink");
      setPartner(2'd0, 1'b0);
      @(posedge clk);
      toggleEn <= 1'b1;
      foreach (dutyPct[d]) begin
         apb(1'b1, A_PREF, d);
         waits(2 * TOG);
         cnt = 0;
         // Whole periods, so the count does not depend on phase
         repeat (4 * TOG) begin
            @(negedge clk);
            cnt += int'(ccState === ST_UNATT_SRC);
         end
         check(cnt, 4 * dutyPct[d] * TOG / 100);
      end
      endTest("toggle duty");
      apb(1'b0, 32'h0fc, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      endTest("unmapped");
      @(posedge clk);
      clkEn <= 1'b0;
      waits(2);
      frozen = ccState;
      waits(TOG + 50);
      check(ccState, frozen);
      @(posedge clk);
      clkEn <= 1'b1;
      endTest("clock enable");
      print_verdict();
   end
endmodule // typec_cc_state_control_tb
